// [rtl/pocu_top.sv]
// Function
// - A rising run-to-position request loads the position command and its parameters onto the selected output.
// - A rising constant-velocity request loads frequency, duty cycle and step count onto the selected output.
// - Each request takes several cycles and then raises exactly one of the success or error flags.
// - The function code's high digit picks less-than or greater-than and its low digit picks one of four sources.
// - In position mode the pulse train stops when the encoder count meets the comparison against the target.
// - Frequency must lie between the minimum and the variant's maximum, otherwise the request fails.
// - Velocity mode emits exactly the step count of pulses, and an all-ones count runs without end.
// - A rising commit request writes the edited preset table to flash and then reports success or error.
// - The error code is kept only until the next command arrives.
//
// Chosen here: the APB slave port and the placing of the registers.
`default_nettype none
module pocu_top
    import pocu_pkg::*;
#(
    parameter bit         FAST_VARIANT = 1'b0,
    parameter logic [7:0] MODULE_NUM   = 8'h01
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [3:0][31:0]  enc_count,
    output logic                   flash_commit_req,
    input  wire logic              flash_commit_done,
    input  wire logic              flash_commit_fail,
    output logic [NUM_OUT-1:0]     pulse_out,
    output logic [NUM_OUT-1:0]     dir_out,
    output logic                   irq
);

    localparam int unsigned MAX_FREQ = FAST_VARIANT ? MAX_FREQ_FAST : MAX_FREQ_BASE;

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic func_valid(input logic [7:0] code);
        return (code[7:4] <= 4'h1) && (code[3:0] <= 4'h3);
    endfunction

    function automatic logic addr_mapped(input logic [7:0] addr);
        return (addr[1:0] == 2'h0) && (addr <= ADDR_IRQ_EN);
    endfunction

    function automatic logic [31:0] duty_thr(input logic [6:0] duty);
        logic [6:0] pct;
        pct = (duty == 7'h0) ? DUTY_HALF : duty;
        return 32'(pct) * 32'(THR_PER_PCT);
    endfunction

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_q1;
    logic rst_sync_n;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_q1     <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_q1     <= 1'b1;
            rst_sync_n <= rst_q1;
        end
    end

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    logic [2:0]          req_bits;
    logic [2:0]          req_prev;
    logic [1:0]          sel_out;
    logic [7:0]          sel_module;
    logic [17:0]         freq_reg;
    logic [6:0]          duty_reg;
    logic [31:0]         count_reg;
    logic [7:0]          func_reg;
    logic [NUM_OUT-1:0]  out_enable;
    logic [IRQ_W-1:0]    irq_en;
    logic [IRQ_W-1:0]    irq_stat;
    logic                ok_flag;
    logic                err_flag;
    logic [15:0]         err_code;
    logic [NUM_OUT-1:0]  ch_done;
    pocu_state_t         state;
    logic                wr_en;
    logic [31:0]         rd_mux;

    assign wr_en   = psel && penable && pwrite && addr_mapped(paddr);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_mapped(paddr);

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            req_bits   <= 3'h0;
            sel_out    <= 2'h0;
            sel_module <= 8'h00;
            freq_reg   <= 18'h0;
            duty_reg   <= 7'h0;
            count_reg  <= 32'h0;
            func_reg   <= 8'h00;
            dir_out    <= '0;
            out_enable <= '0;
            irq_en     <= '0;
        end else if (wr_en) begin
            unique case (paddr)
                ADDR_REQUEST:  req_bits <= pwdata[2:0];
                ADDR_SELECT: begin
                    sel_out    <= pwdata[1:0];
                    sel_module <= pwdata[15:8];
                end
                ADDR_FREQ:     freq_reg  <= pwdata[17:0];
                ADDR_DUTY:     duty_reg  <= pwdata[6:0];
                ADDR_COUNT:    count_reg <= pwdata;
                ADDR_FUNCTION: func_reg  <= pwdata[7:0];
                ADDR_OUTCTL: begin
                    dir_out    <= pwdata[3:0];
                    out_enable <= pwdata[7:4];
                end
                ADDR_IRQ_EN:   irq_en <= pwdata[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        rd_mux = 32'h0;
        unique case (paddr)
            ADDR_REQUEST:  rd_mux = {29'h0, req_bits};
            ADDR_SELECT:   rd_mux = {16'h0, sel_module, 6'h0, sel_out};
            ADDR_FREQ:     rd_mux = {14'h0, freq_reg};
            ADDR_DUTY:     rd_mux = {25'h0, duty_reg};
            ADDR_COUNT:    rd_mux = count_reg;
            ADDR_FUNCTION: rd_mux = {24'h0, func_reg};
            ADDR_STATUS:   rd_mux = {24'h0, ch_done, 1'b0, state != ST_IDLE, err_flag, ok_flag};
            ADDR_ERRCODE:  rd_mux = {16'h0, err_code};
            ADDR_OUTCTL:   rd_mux = {24'h0, out_enable, dir_out};
            ADDR_IRQ_STAT: rd_mux = {26'h0, irq_stat};
            ADDR_IRQ_EN:   rd_mux = {26'h0, irq_en};
            default:       rd_mux = 32'h0;
        endcase
    end

    // Read data is captured in the setup phase and shown in the access phase.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------------
    logic [2:0]   req_rise;
    logic         start;
    logic         finish;
    logic [3:0]   wait_cnt;
    pocu_cmd_t    cmd_q;
    pocu_cmd_t    next_cmd;
    logic [15:0]  next_err;

    assign req_rise = req_bits & ~req_prev;
    assign start    = (state == ST_IDLE) && (|req_rise);
    assign finish   = (state == ST_CHECK) && (wait_cnt == 4'(CHECK_CYC - 1));

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            req_prev <= 3'h0;
        end else begin
            req_prev <= req_bits;
        end
    end

    always_comb begin
        next_cmd = CMD_FLASH;
        if (req_rise[REQ_RTP_BIT]) begin
            next_cmd = CMD_RTP;
        end else if (req_rise[REQ_VEL_BIT]) begin
            next_cmd = CMD_VEL;
        end
    end

    // Parameters are judged at the end of the check window, so the host may
    // still settle them during the first cycles after the request edge.
    always_comb begin
        next_err = ERR_NONE;
        if (sel_module != MODULE_NUM) begin
            next_err = ERR_UNKNOWN;
        end else if (cmd_q != CMD_FLASH) begin
            if ((freq_reg < 18'(MIN_FREQ_HZ)) || (freq_reg > 18'(MAX_FREQ))) begin
                next_err = ERR_RANGE;
            end else if (duty_reg > DUTY_MAX) begin
                next_err = ERR_RANGE;
            end else if ((cmd_q == CMD_RTP) && !func_valid(func_reg)) begin
                next_err = ERR_FUNCTION;
            end else if ((cmd_q == CMD_RTP) && (count_reg > POS_MAX)) begin
                next_err = ERR_RANGE;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state    <= ST_IDLE;
            cmd_q    <= CMD_RTP;
            wait_cnt <= 4'h0;
            ok_flag  <= 1'b0;
            err_flag <= 1'b0;
            err_code <= ERR_NONE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (start) begin
                        state    <= ST_CHECK;
                        cmd_q    <= next_cmd;
                        wait_cnt <= 4'h0;
                        ok_flag  <= 1'b0;
                        err_flag <= 1'b0;
                        err_code <= ERR_NONE;
                    end
                end
                ST_CHECK: begin
                    if (!finish) begin
                        wait_cnt <= wait_cnt + 4'h1;
                    end else if (next_err != ERR_NONE) begin
                        err_flag <= 1'b1;
                        err_code <= next_err;
                        state    <= ST_IDLE;
                    end else if (cmd_q == CMD_FLASH) begin
                        state <= ST_FLASH;
                    end else begin
                        ok_flag <= 1'b1;
                        state   <= ST_IDLE;
                    end
                end
                ST_FLASH: begin
                    if (flash_commit_done) begin
                        ok_flag  <= !flash_commit_fail;
                        err_flag <= flash_commit_fail;
                        err_code <= flash_commit_fail ? ERR_FLASH : ERR_NONE;
                        state    <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign flash_commit_req = (state == ST_FLASH);

    // ------------------------------------------------------------------
    // Pulse outputs
    // ------------------------------------------------------------------
    logic [NUM_OUT-1:0] load_vec;
    logic               load_pos;

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            load_vec <= '0;
            load_pos <= 1'b0;
        end else begin
            load_vec <= '0;
            load_pos <= (cmd_q == CMD_RTP);
            if (finish && (next_err == ERR_NONE) && (cmd_q != CMD_FLASH)) begin
                load_vec <= NUM_OUT'(1) << sel_out;
            end
        end
    end

    for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
        pocu_pulse_gen u_gen (
            .mclk          (mclk),
            .rst_sync_n    (rst_sync_n),
            .load          (load_vec[g]),
            .load_position (load_pos),
            .load_freq     (freq_reg),
            .load_thr      (duty_thr(duty_reg)),
            .load_limit    (count_reg),
            .load_greater  (func_reg[4]),
            .load_src      (func_reg[1:0]),
            .enc_count     (enc_count),
            .enable        (out_enable[g]),
            .pulse         (pulse_out[g]),
            .done          (ch_done[g])
        );
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    logic [IRQ_W-1:0] ev_prev;
    logic [IRQ_W-1:0] ev_now;
    logic [IRQ_W-1:0] irq_clr;

    assign ev_now  = {ch_done, err_flag, ok_flag};
    assign irq_clr = (wr_en && paddr == ADDR_IRQ_CLR) ? pwdata[IRQ_W-1:0] : '0;
    assign irq     = |(irq_stat & irq_en);

    // A new event in the same cycle as its clear keeps the bit set.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ev_prev  <= '0;
            irq_stat <= '0;
        end else begin
            ev_prev  <= ev_now;
            irq_stat <= (irq_stat & ~irq_clr) | (ev_now & ~ev_prev);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_sync_n);

    position_load_a: assert property (finish && cmd_q == CMD_RTP
        && next_err == ERR_NONE |=> load_vec == (NUM_OUT'(1) << sel_out) && load_pos)
        else $error("position command not loaded");
    velocity_load_a: assert property (finish && cmd_q == CMD_VEL
        && next_err == ERR_NONE |=> load_vec == (NUM_OUT'(1) << sel_out) && !load_pos)
        else $error("velocity command not loaded");
    result_delay_a: assert property (start && next_cmd != CMD_FLASH
        |=> (!ok_flag && !err_flag) [*8] ##1 (ok_flag ^ err_flag))
        else $error("request result timing wrong");
    single_result_a: assert property (!(ok_flag && err_flag))
        else $error("success and error both set");
    func_decode_a: assert property (finish && cmd_q == CMD_RTP
        && sel_module == MODULE_NUM && !func_valid(func_reg)
        && freq_reg >= 18'(MIN_FREQ_HZ) && freq_reg <= 18'(MAX_FREQ) && duty_reg <= DUTY_MAX
        |=> err_flag && err_code == ERR_FUNCTION)
        else $error("bad function code accepted");
    freq_range_a: assert property (finish && cmd_q != CMD_FLASH
        && sel_module == MODULE_NUM && freq_reg < 18'(MIN_FREQ_HZ)
        |=> err_flag && load_vec == '0)
        else $error("low frequency accepted");
    flash_commit_a: assert property (flash_commit_req && flash_commit_done
        && !flash_commit_fail |=> ok_flag && !flash_commit_req)
        else $error("flash commit result missing");
    code_cleared_a: assert property (start |=> err_code == ERR_NONE && state == ST_CHECK)
        else $error("error code kept past new command");
    duty_default_a: assert property (load_vec[0] && duty_reg == 7'h0
        |=> g_out[0].u_gen.thr == 32'(CLK_HZ / 2))
        else $error("zero duty not treated as half");

    position_ok_c: cover property (finish && cmd_q == CMD_RTP ##1 ok_flag);
    velocity_err_c: cover property (finish && cmd_q == CMD_VEL ##1 err_flag);
    flash_ok_c: cover property (flash_commit_req && flash_commit_done ##1 ok_flag);
    channel_done_c: cover property ($rose(ch_done[0]));

endmodule
`default_nettype wire

// [rtl/pocu_pkg.sv]
`default_nettype none
package pocu_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_REQUEST  = 8'h00;
    localparam logic [7:0] ADDR_SELECT   = 8'h04;
    localparam logic [7:0] ADDR_FREQ     = 8'h08;
    localparam logic [7:0] ADDR_DUTY     = 8'h0c;
    localparam logic [7:0] ADDR_COUNT    = 8'h10;
    localparam logic [7:0] ADDR_FUNCTION = 8'h14;
    localparam logic [7:0] ADDR_STATUS   = 8'h18;
    localparam logic [7:0] ADDR_ERRCODE  = 8'h1c;
    localparam logic [7:0] ADDR_OUTCTL   = 8'h20;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
    localparam logic [7:0] ADDR_IRQ_CLR  = 8'h28;
    localparam logic [7:0] ADDR_IRQ_EN   = 8'h2c;

    // ------------------------------------------------------------------
    // Field positions and sizes
    // ------------------------------------------------------------------
    localparam int REQ_RTP_BIT   = 0;
    localparam int REQ_VEL_BIT   = 1;
    localparam int REQ_FLASH_BIT = 2;
    localparam int NUM_OUT       = 4;
    localparam int IRQ_W         = 6;
    localparam int IRQ_OK_BIT    = 0;
    localparam int IRQ_ERR_BIT   = 1;
    localparam int IRQ_DONE_LSB  = 2;

    // ------------------------------------------------------------------
    // Limits, timing and error codes
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned MIN_FREQ_HZ   = 20;
    localparam int unsigned MAX_FREQ_BASE = 25_000;
    localparam int unsigned MAX_FREQ_FAST = 250_000;
    localparam logic [31:0] POS_MAX       = 32'h7fff3e20;
    localparam logic [31:0] STEP_FOREVER  = 32'hffffffff;
    localparam logic [6:0]  DUTY_MAX      = 7'h63;
    localparam logic [6:0]  DUTY_HALF     = 7'h32;
    localparam int unsigned THR_PER_PCT   = CLK_HZ / 100;
    localparam int unsigned CHECK_TIME_NS = 40;
    localparam int unsigned CHECK_CYC     = (CHECK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] ERR_NONE      = 16'h0000;
    localparam logic [15:0] ERR_UNKNOWN   = 16'h0064;
    localparam logic [15:0] ERR_FUNCTION  = 16'h006a;
    localparam logic [15:0] ERR_RANGE     = 16'h006f;
    localparam logic [15:0] ERR_FLASH     = 16'h0078;

    typedef enum logic [1:0] {CMD_RTP, CMD_VEL, CMD_FLASH} pocu_cmd_t;
    typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_FLASH} pocu_state_t;

endpackage
`default_nettype wire

// [rtl/pocu_pulse_gen.sv]
`default_nettype none
module pocu_pulse_gen
    import pocu_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst_sync_n,
    input  wire logic              load,
    input  wire logic              load_position,
    input  wire logic [17:0]       load_freq,
    input  wire logic [31:0]       load_thr,
    input  wire logic [31:0]       load_limit,
    input  wire logic              load_greater,
    input  wire logic [1:0]        load_src,
    input  wire logic [3:0][31:0]  enc_count,
    input  wire logic              enable,
    output logic                   pulse,
    output logic                   done
);

    logic              mode_pos;
    logic              greater;
    logic [1:0]        src;
    logic [31:0]       freq;
    logic [31:0]       thr;
    logic [31:0]       limit;
    logic [31:0]       acc;
    logic [31:0]       emitted;
    logic              armed;
    logic              run;
    logic              wrap;
    logic              hit;
    logic              last;

    assign run  = enable && armed && !done;
    assign wrap = run && ((acc + freq) >= CLK_HZ);
    assign hit  = greater ? (enc_count[src] > limit) : (enc_count[src] < limit);
    assign last = wrap && !mode_pos && (limit != STEP_FOREVER) && (emitted + 32'h1 == limit);

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode_pos <= 1'b0;
            greater  <= 1'b0;
            src      <= 2'h0;
            freq     <= 32'h0;
            thr      <= 32'h0;
            limit    <= 32'h0;
            armed    <= 1'b0;
        end else if (load) begin
            mode_pos <= load_position;
            greater  <= load_greater;
            src      <= load_src;
            freq     <= {14'h0, load_freq};
            thr      <= load_thr;
            limit    <= load_limit;
            armed    <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Phase accumulator: one wrap per output period, no divider needed.
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            acc <= 32'h0;
        end else if (load || !run) begin
            acc <= 32'h0;
        end else if (wrap) begin
            acc <= acc + freq - CLK_HZ;
        end else begin
            acc <= acc + freq;
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            emitted <= 32'h0;
        end else if (load) begin
            emitted <= 32'h0;
        end else if (wrap) begin
            emitted <= emitted + 32'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            done <= 1'b0;
        end else if (load) begin
            done <= !load_position && (load_limit == 32'h0);
        end else if (run && ((mode_pos && hit) || last)) begin
            done <= 1'b1;
        end
    end

    // The output stays low once done, until the next load rearms it.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pulse <= 1'b0;
        end else begin
            pulse <= run && !last && !(mode_pos && hit) && (acc < thr);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_sync_n);

    position_stop_a: assert property (run && mode_pos && hit && !load |=> done && !pulse)
        else $error("position stop not taken");
    duty_split_a: assert property (run && !last && !hit && (acc < thr) |=> pulse)
        else $error("pulse low inside on-time");
    step_exact_a: assert property ($rose(done) && !mode_pos && !$past(load) |-> emitted == limit)
        else $error("pulse count differs from step count");
    hold_low_a: assert property (done && !load |=> !pulse)
        else $error("pulse after completion");
    forever_run_a: assert property (!mode_pos && limit == STEP_FOREVER && armed && !load |=> !done)
        else $error("endless run stopped");

endmodule
`default_nettype wire

// [dv/pocu_flash_model.sv]
`default_nettype none
module pocu_flash_model (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic req,
    input  wire logic fail_mode,
    output logic      done,
    output logic      fail
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] cnt;
    // A failing commit answers fast and a good one slowly, so both paces are seen.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 6'h00;
            done <= 1'b0;
        end else begin
            done <= req && !done && cnt == (fail_mode ? 6'h02 : 6'h28);
            cnt <= (req && !done) ? cnt + 6'h01 : 6'h00;
        end
    end
    // Outside the answer the fail line shows the opposite of the verdict.
    assign fail = done ? fail_mode : !fail_mode;
endmodule
`default_nettype wire

// [dv/tb.sv]
`default_nettype none
module tb import pocu_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic             mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, fmode = 0;
    logic             pv = 0, pready, pslverr, se, irq, fq, fd, ff;
    logic [7:0]       paddr = 8'h00;
    logic [31:0]      pwdata = 32'h0, prdata, rd;
    logic [3:0][31:0] enc = '0;
    logic [3:0]       po, dr;
    int               n_fail = 0, n_tests = 0, np = 0;
    pocu_top dut(.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .enc_count(enc), .flash_commit_req(fq), .flash_commit_done(fd),
        .flash_commit_fail(ff), .pulse_out(po), .dir_out(dr), .irq);
    pocu_flash_model fm(.mclk, .rst_n, .req(fq), .fail_mode(fmode), .done(fd), .fail(ff));
    initial forever #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        pv <= po[0];
        if (po[0] && !pv)
            np <= np + 1;
    end
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int i;
        @(posedge mclk);
        psel <= 1;
        penable <= 0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        for (i = 0; i < 16; i++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            n_fail++;
            tally_and_finish();
        end
        rd = prdata;
        se = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wst(input logic [31:0] m, input int n);
        int i;
        for (i = 0; i < n; i++) begin
            apb(ADDR_STATUS, 0, 0);
            if ((rd & m) !== 32'h0) break;
        end
        if (i == n) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    task automatic cmd(input int b, input logic [1:0] fl, input logic [15:0] ec);
        apb(ADDR_REQUEST, 1, 0);
        apb(ADDR_REQUEST, 1, 32'h1 << b);
        repeat (3) @(posedge mclk);
        wst(32'h3, 100);
        chk("flags", {30'h0, fl}, {30'h0, rd[1:0]});
        apb(ADDR_ERRCODE, 0, 0);
        chk("errcode", {16'h0, ec}, rd);
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1;
        repeat (3) @(posedge mclk);
        apb(ADDR_STATUS, 0, 0);
        chk("status", 0, rd);
        apb(8'h30, 0, 0);
        chk("pslverr", 1, {31'h0, se});
        apb(ADDR_IRQ_EN, 1, 1);
        apb(ADDR_SELECT, 1, 32'h100);
        apb(ADDR_FREQ, 1, 32'h13);
        apb(ADDR_COUNT, 1, 3);
        cmd(REQ_VEL_BIT, 2'b10, ERR_RANGE);
        apb(ADDR_FREQ, 1, 32'h4e20);
        apb(ADDR_SELECT, 1, 32'h200);
        cmd(REQ_VEL_BIT, 2'b10, ERR_UNKNOWN);
        apb(ADDR_SELECT, 1, 32'h100);
        cmd(REQ_VEL_BIT, 2'b01, ERR_NONE);
        chk("irq", 1, {31'h0, irq});
        apb(ADDR_IRQ_CLR, 1, 3);
        @(posedge mclk);
        chk("irq", 0, {31'h0, irq});
        apb(ADDR_OUTCTL, 1, 1);
        apb(ADDR_OUTCTL, 1, 32'h11);
        chk("dir", 1, {28'h0, dr});
        wst(32'h10, 12000);
        chk("pulses", 3, 32'(np));
        repeat (20) @(posedge mclk);
        chk("pulse_idle", 0, {31'h0, po[0]});
        apb(ADDR_FUNCTION, 1, 32'h20);
        cmd(REQ_RTP_BIT, 2'b10, ERR_FUNCTION);
        apb(ADDR_FUNCTION, 1, 32'h13);
        apb(ADDR_COUNT, 1, 32'd100);
        cmd(REQ_RTP_BIT, 2'b01, ERR_NONE);
        enc[3] <= 32'd200;
        wst(32'h10, 100);
        apb(ADDR_COUNT, 1, STEP_FOREVER);
        cmd(REQ_VEL_BIT, 2'b01, ERR_NONE);
        repeat (100) @(posedge mclk);
        apb(ADDR_STATUS, 0, 0);
        chk("endless", 0, rd & 32'h10);
        fmode <= 1;
        cmd(REQ_FLASH_BIT, 2'b10, ERR_FLASH);
        fmode <= 0;
        cmd(REQ_FLASH_BIT, 2'b01, ERR_NONE);
        tally_and_finish();
    end
endmodule
`default_nettype wire
